// ===== hdl/parallel_video_data_port_pkg.sv
package parallel_video_data_port_pkg;

  // =====================================================
  // widths and field positions
  localparam int DATA_W = 16;
  localparam int FS_N = 3;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;
  localparam logic [7:0] PRE_ONES = 8'hFF;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [3:0] WIDTH_SEL_8 = 4'h0;
  localparam logic [3:0] WIDTH_SEL_MAX = 4'h7;
  localparam logic [4:0] WIDTH_8 = 5'h08;
  localparam logic [4:0] WIDTH_BASE = 5'h09;
  localparam logic [4:0] WIDTH_16 = 5'h10;

  // =====================================================
  // modes and states
  typedef enum logic [2:0] {
    MODE_GP_IN, MODE_GP_FRAME, MODE_GP_OUT,
    MODE_ITU_ACTIVE, MODE_ITU_VBI, MODE_ITU_FIELD
  } port_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_FS, ST_DELAY, ST_MOVE, ST_SEEK, ST_VIDEO, ST_DONE
  } eng_state_t;

  // =====================================================
  // carriers
  typedef struct packed {
    logic enable;
    port_mode_t mode;
    logic [3:0] width_sel;
    logic [2:0] fs_dir;
    logic [1:0] fs_count;
    logic [15:0] sync_to_data_delay;
    logic [15:0] transfer_count;
    logic [15:0] line_period;
    logic [15:0] hsync_width;
    logic [15:0] frame_lines;
    logic [15:0] vsync_lines;
  } port_cfg_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic synced;
    logic field;
    logic vblank;
    logic line_start_preamble;
    logic field_start;
  } port_status_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sample_t;

  typedef struct packed {
    logic [2:0] pclk_s;
    logic [2:0] fs_s1;
    logic [2:0] fs_s2;
    logic [2:0] fs_prev;
    logic [15:0] d_s1;
    logic [15:0] d_s2;
    eng_state_t st;
    logic [15:0] dly;
    logic [15:0] cnt;
    logic [15:0] hcnt;
    logic [15:0] vcnt;
    logic [3:0][15:0] hist;
    logic [3:0] hist_ctl;
    logic [3:0] hist_rgn;
    logic in_av;
    logic vblank;
    logic field;
    logic synced;
    logic [2:0] fs_out;
    logic [2:0] fs_oe;
    logic [15:0] dout;
    logic doe;
    sample_t rx;
    logic tx_ready;
    port_status_t stat;
  } engine_state_t;

  localparam engine_state_t ENGINE_RESET = '0;

endpackage

// ===== hdl/parallel_video_data_port.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - two independent port instances, each for converters, video or general parts.
// - each port has one input clock, three frame syncs, sixteen data lines.
// - each frame sync line can be input or output.
// - general mode moves up to 16-bit words one direction at a time.
// - video mode moves 8 or 10 bit samples one direction at a time.
// - video mode detects and decodes embedded line and field preambles.
// - submodes: all inputs; syncs out data in; all outputs.
// - general input mode starts reading on the first frame sync input.
// - after that sync, wait the programmed delay in port clocks.
// - input mode reads exactly the programmed transfer count of samples; a count of zero reads one.
// - sample widths of 8 bits and 10 through 16 bits, selectable.
// - frame capture drives sync one as hsync, sync two as vsync.
// - output mode drives data with one to three generated syncs.
// - active video mode reads nothing between end and start codes, or vblank.
// - active video mode drops the embedded control sequences.
// - active video mode syncs to field one, then waits for start code.
// - active video mode transfer count is active lines per frame.
// - blanking mode passes only samples inside vertical blanking.
// - entire field mode passes every sample, control words included.
// - entire field mode starts at once after field one sync.

// =====================================================
// one port engine
module port_engine (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration and status
  input wire parallel_video_data_port_pkg::port_cfg_t cfg,
  output var parallel_video_data_port_pkg::port_status_t status,
  // pins
  input wire logic port_input_clock,
  input wire logic [2:0] frame_sync_in,
  output var logic [2:0] frame_sync_out,
  output var logic [2:0] frame_sync_oe,
  input wire logic [15:0] data_in,
  output var logic [15:0] data_out,
  output var logic data_oe,
  // memory side
  output var parallel_video_data_port_pkg::sample_t rx,
  input wire logic [15:0] tx_data,
  input wire logic tx_valid,
  output var logic tx_ready
);

  parallel_video_data_port_pkg::engine_state_t s;
  parallel_video_data_port_pkg::engine_state_t next_s;

  function automatic logic [4:0] sample_width(input logic [3:0] sel);
    if (sel == parallel_video_data_port_pkg::WIDTH_SEL_8) begin
      return parallel_video_data_port_pkg::WIDTH_8;
    end
    if (sel >= parallel_video_data_port_pkg::WIDTH_SEL_MAX) begin
      return parallel_video_data_port_pkg::WIDTH_16;
    end
    return 5'({1'b0, sel}) + parallel_video_data_port_pkg::WIDTH_BASE;
  endfunction

  function automatic logic [15:0] width_mask(input logic [3:0] sel);
    return 16'hFFFF >> (parallel_video_data_port_pkg::WIDTH_16 -
      sample_width(sel));
  endfunction

  // top eight bits, so 10-bit video decodes like 8-bit
  function automatic logic [7:0] top8(input logic [15:0] w,
                                      input logic [3:0] sel);
    logic [15:0] sh;
    sh = w >> (sample_width(sel) - parallel_video_data_port_pkg::WIDTH_8);
    return sh[7:0];
  endfunction

  logic rise;
  logic [15:0] word;
  logic [7:0] xy;
  logic itu;
  logic is_xy;
  logic f1_start;
  logic frame_start;
  logic hs;
  logic vs;
  logic rgn;
  logic [2:0] used;

  assign rise = s.pclk_s[1] & ~s.pclk_s[2];

  // =====================================================
  // next state
  always_comb begin
    next_s = s;
    word = s.d_s2 & width_mask(cfg.width_sel);
    xy = top8(word, cfg.width_sel);
    itu = cfg.mode inside {parallel_video_data_port_pkg::MODE_ITU_ACTIVE,
      parallel_video_data_port_pkg::MODE_ITU_VBI,
      parallel_video_data_port_pkg::MODE_ITU_FIELD};
    frame_start = (s.hcnt == 16'h0000) && (s.vcnt == 16'h0000);
    hs = s.hcnt < cfg.hsync_width;
    vs = s.vcnt < cfg.vsync_lines;
    // preamble is ones, zero, zero, then the xy status word
    is_xy = itu && xy[7] &&
      top8(s.hist[2], cfg.width_sel) == parallel_video_data_port_pkg::PRE_ONES &&
      top8(s.hist[1], cfg.width_sel) == parallel_video_data_port_pkg::PRE_ZERO &&
      top8(s.hist[0], cfg.width_sel) == parallel_video_data_port_pkg::PRE_ZERO;
    f1_start = is_xy && !xy[parallel_video_data_port_pkg::XY_F] && s.field;
    case (cfg.mode)
      parallel_video_data_port_pkg::MODE_ITU_ACTIVE: rgn = s.in_av;
      parallel_video_data_port_pkg::MODE_ITU_VBI: rgn = s.vblank;
      default: rgn = 1'b1;
    endcase
    case (cfg.mode)
      parallel_video_data_port_pkg::MODE_GP_FRAME: used = 3'h3;
      parallel_video_data_port_pkg::MODE_GP_OUT: used = (cfg.fs_count >= 2'h3) ?
        3'h7 : (cfg.fs_count == 2'h2 ? 3'h3 : 3'h1);
      default: used = 3'h0;
    endcase
    // pin synchronisers; the first stage feeds only the second
    next_s.pclk_s = {s.pclk_s[1:0], port_input_clock};
    next_s.fs_s1 = frame_sync_in;
    next_s.fs_s2 = s.fs_s1;
    next_s.d_s1 = data_in;
    next_s.d_s2 = s.d_s1;
    next_s.rx.valid = 1'b0;
    next_s.tx_ready = 1'b0;
    next_s.stat.done = 1'b0;
    next_s.stat.line_start_preamble = 1'b0;
    next_s.stat.field_start = 1'b0;
    if (!cfg.enable) begin
      next_s.st = parallel_video_data_port_pkg::ST_IDLE;
      next_s.synced = 1'b0;
      next_s.fs_oe = 3'h0;
      next_s.doe = 1'b0;
      next_s.hcnt = 16'h0000;
      next_s.vcnt = 16'h0000;
    end else if (rise) begin
      // a rise is seen only if the port clock is at most half clk
      next_s.fs_prev = s.fs_s2;
      if (s.hcnt >= cfg.line_period - 16'h0001) begin
        next_s.hcnt = 16'h0000;
        next_s.vcnt = (s.vcnt >= cfg.frame_lines - 16'h0001) ?
          16'h0000 : s.vcnt + 16'h0001;
      end else begin
        next_s.hcnt = s.hcnt + 16'h0001;
      end
      next_s.fs_out = {hs & vs, vs, hs};
      next_s.fs_oe = used & cfg.fs_dir;
      next_s.doe = cfg.mode == parallel_video_data_port_pkg::MODE_GP_OUT;
      // four-deep history so a whole preamble can be withdrawn
      next_s.hist = {s.hist[2:0], word};
      next_s.hist_ctl = {s.hist_ctl[2:0], 1'b0};
      next_s.hist_rgn = {s.hist_rgn[2:0], rgn & s.synced};
      if (is_xy) begin
        next_s.hist_ctl = 4'hF;
        next_s.field = xy[parallel_video_data_port_pkg::XY_F];
        next_s.vblank = xy[parallel_video_data_port_pkg::XY_V];
        next_s.in_av = !xy[parallel_video_data_port_pkg::XY_H] &&
          !xy[parallel_video_data_port_pkg::XY_V];
        next_s.stat.line_start_preamble = !xy[parallel_video_data_port_pkg::XY_H];
        next_s.stat.field_start = xy[parallel_video_data_port_pkg::XY_F] != s.field;
        if (f1_start) begin
          next_s.synced = 1'b1;
        end
      end
      case (s.st)
        parallel_video_data_port_pkg::ST_IDLE: begin
          next_s.cnt = 16'h0000;
          next_s.dly = 16'h0000;
          next_s.st = itu ? parallel_video_data_port_pkg::ST_SEEK :
            parallel_video_data_port_pkg::ST_WAIT_FS;
        end
        parallel_video_data_port_pkg::ST_WAIT_FS: begin
          if ((cfg.mode == parallel_video_data_port_pkg::MODE_GP_IN) ?
              (s.fs_s2[0] & ~s.fs_prev[0]) : frame_start) begin
            next_s.st = (cfg.sync_to_data_delay == 16'h0000) ?
              parallel_video_data_port_pkg::ST_MOVE :
              parallel_video_data_port_pkg::ST_DELAY;
          end
        end
        parallel_video_data_port_pkg::ST_DELAY: begin
          next_s.dly = s.dly + 16'h0001;
          if (s.dly + 16'h0001 >= cfg.sync_to_data_delay) begin
            next_s.st = parallel_video_data_port_pkg::ST_MOVE;
          end
        end
        parallel_video_data_port_pkg::ST_MOVE: begin
          if (cfg.mode == parallel_video_data_port_pkg::MODE_GP_OUT) begin
            // an empty source holds the last word on the pins
            next_s.dout = tx_valid ? (tx_data & width_mask(cfg.width_sel)) :
              s.dout;
            next_s.tx_ready = tx_valid;
          end else begin
            next_s.rx.valid = 1'b1;
            next_s.rx.data = word;
          end
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt + 16'h0001 >= cfg.transfer_count) begin
            next_s.st = parallel_video_data_port_pkg::ST_DONE;
            next_s.stat.done = 1'b1;
          end
        end
        parallel_video_data_port_pkg::ST_SEEK: begin
          if (f1_start) begin
            next_s.st = parallel_video_data_port_pkg::ST_VIDEO;
          end
        end
        parallel_video_data_port_pkg::ST_VIDEO: begin
          if (s.hist_rgn[3] && !(s.hist_ctl[3] &&
              cfg.mode != parallel_video_data_port_pkg::MODE_ITU_FIELD)) begin
            next_s.rx.valid = 1'b1;
            next_s.rx.data = s.hist[3];
          end
          if (cfg.mode == parallel_video_data_port_pkg::MODE_ITU_ACTIVE) begin
            if (is_xy && s.in_av && xy[parallel_video_data_port_pkg::XY_H]) begin
              next_s.cnt = s.cnt + 16'h0001;
              if (s.cnt + 16'h0001 >= cfg.transfer_count) begin
                next_s.st = parallel_video_data_port_pkg::ST_DONE;
                next_s.stat.done = 1'b1;
              end
            end
          end else if (f1_start) begin
            next_s.st = parallel_video_data_port_pkg::ST_DONE;
            next_s.stat.done = 1'b1;
          end
        end
        parallel_video_data_port_pkg::ST_DONE: begin
          next_s.st = parallel_video_data_port_pkg::ST_DONE;
        end
        default: begin
          next_s.st = parallel_video_data_port_pkg::ST_IDLE;
        end
      endcase
    end
    next_s.stat.busy = !(next_s.st inside {parallel_video_data_port_pkg::ST_IDLE,
      parallel_video_data_port_pkg::ST_DONE});
    next_s.stat.synced = next_s.synced;
    next_s.stat.field = next_s.field;
    next_s.stat.vblank = next_s.vblank;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= parallel_video_data_port_pkg::ENGINE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign status = s.stat;
  assign frame_sync_out = s.fs_out;
  assign frame_sync_oe = s.fs_oe;
  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign rx = s.rx;
  assign tx_ready = s.tx_ready;

  // =====================================================
  // checks
  chk_input_no_drive: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg.mode == parallel_video_data_port_pkg::MODE_GP_IN) ##1
    (cfg.mode == parallel_video_data_port_pkg::MODE_GP_IN) |-> frame_sync_oe == 3'h0)
    else $error("frame sync driven in input mode");
  chk_data_dir_one: assert property (@(posedge clk) disable iff (!rst_b)
    data_oe |-> !rx.valid)
    else $error("data driven while sampling");
  chk_rx_width_mask: assert property (@(posedge clk) disable iff (!rst_b)
    rx.valid && !itu |-> (rx.data & ~width_mask(cfg.width_sel)) == 16'h0000)
    else $error("sample wider than selected width");
  chk_delay_no_read: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == parallel_video_data_port_pkg::ST_DELAY |-> !rx.valid)
    else $error("read during sync delay");
  chk_count_limit: assert property (@(posedge clk) disable iff (!rst_b)
    // a zero count runs as one sample
    rx.valid && !itu |->
    (s.cnt <= cfg.transfer_count || s.cnt == 16'h0001))
    else $error("more samples than transfer count");
  chk_active_synced: assert property (@(posedge clk) disable iff (!rst_b)
    rx.valid && itu |-> s.synced && $past(s.st) == parallel_video_data_port_pkg::ST_VIDEO)
    else $error("video sample before field one sync");
  chk_capture_syncs: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == parallel_video_data_port_pkg::ST_MOVE &&
    cfg.mode == parallel_video_data_port_pkg::MODE_GP_FRAME && $stable(cfg) |->
    frame_sync_oe[1:0] == cfg.fs_dir[1:0])
    else $error("capture syncs not driven");
  chk_sample_on_edge: assert property (@(posedge clk) disable iff (!rst_b)
    rx.valid |-> $past(rise))
    else $error("sample taken without a port clock rise");

endmodule // port_engine

// =====================================================
// top: independent port instances
module parallel_video_data_port #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration and status
  input wire parallel_video_data_port_pkg::port_cfg_t cfg [NUM_PORTS],
  output var parallel_video_data_port_pkg::port_status_t status [NUM_PORTS],
  // pins
  input wire logic [NUM_PORTS-1:0] port_input_clock,
  input wire logic [NUM_PORTS-1:0][2:0] frame_sync_in,
  output var logic [NUM_PORTS-1:0][2:0] frame_sync_out,
  output var logic [NUM_PORTS-1:0][2:0] frame_sync_oe,
  input wire logic [NUM_PORTS-1:0][15:0] data_in,
  output var logic [NUM_PORTS-1:0][15:0] data_out,
  output var logic [NUM_PORTS-1:0] data_oe,
  // memory side
  output var parallel_video_data_port_pkg::sample_t rx [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0][15:0] tx_data,
  input wire logic [NUM_PORTS-1:0] tx_valid,
  output var logic [NUM_PORTS-1:0] tx_ready
);

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    port_engine u_engine (
      .clk(clk),
      .rst_b(rst_b),
      .cfg(cfg[i]),
      .status(status[i]),
      .port_input_clock(port_input_clock[i]),
      .frame_sync_in(frame_sync_in[i]),
      .frame_sync_out(frame_sync_out[i]),
      .frame_sync_oe(frame_sync_oe[i]),
      .data_in(data_in[i]),
      .data_out(data_out[i]),
      .data_oe(data_oe[i]),
      .rx(rx[i]),
      .tx_data(tx_data[i]),
      .tx_valid(tx_valid[i]),
      .tx_ready(tx_ready[i])
    );
  end

endmodule // parallel_video_data_port
`default_nettype wire

// ===== test/video_partner.sv
`timescale 1ns/10ps
`default_nettype none
module video_partner (
  // pins toward the port
  output var logic pclk,
  output var logic [2:0] fs,
  output var logic [15:0] data
);
  // =====================================================
  // one word per port clock; clock stands still between words
  initial begin
    pclk = 1'b0;
    fs = 3'h0;
    data = 16'h0000;
  end

  task automatic tick(input logic [15:0] d, input logic [2:0] f);
    data = d;
    fs = f;
    #80 pclk = 1'b1;
    #80 pclk = 1'b0;
    // hold has run out: show the inverse, not the last word
    data = ~d;
  endtask
endmodule // video_partner
`default_nettype wire

// ===== test/parallel_video_data_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module parallel_video_data_port_tb;
  // =====================================================
  // signals
  logic clk;
  logic rst_b;
  parallel_video_data_port_pkg::port_cfg_t cfg [2];
  parallel_video_data_port_pkg::port_status_t status [2];
  parallel_video_data_port_pkg::sample_t rx [2];
  logic [1:0][2:0] fs_out, fs_oe, fs_in;
  logic [1:0][15:0] d_out, d_in, tx_data;
  logic [1:0] d_oe, tx_valid, tx_ready;
  logic p_clk;
  logic [2:0] p_fs;
  logic [15:0] p_d;
  logic [15:0] rxq [$];
  logic [15:0] expq [$];
  int n_fail = 0;
  int checks = 0;
  int done_n, rdy_n, b_n, sol_n, fld_n;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  parallel_video_data_port #(.NUM_PORTS(2)) parallel_video_data_port_i (
    .clk(clk), .rst_b(rst_b), .cfg(cfg), .status(status),
    .port_input_clock({p_clk, p_clk}), .frame_sync_in(fs_in),
    .frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .data_in(d_in),
    .data_out(d_out), .data_oe(d_oe), .rx(rx), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  video_partner video_partner_i (.pclk(p_clk), .fs(p_fs), .data(p_d));

  // =====================================================
  // pin resolution: the driving party wins per line
  for (genvar g = 0; g < 2; g++) begin : g_wire
    assign fs_in[g] = (fs_oe[g] & fs_out[g]) | (~fs_oe[g] & p_fs);
    assign d_in[g] = d_oe[g] ? d_out[g] : p_d;
  end

  always @(posedge clk) begin
    if (rx[0].valid === 1'b1) rxq.push_back(rx[0].data);
    if (status[0].done === 1'b1) done_n++;
    if (tx_ready[0] === 1'b1) rdy_n++;
    if (rx[1].valid === 1'b1) b_n++;
    if (status[0].line_start_preamble === 1'b1) sol_n++;
    if (status[0].field_start === 1'b1) fld_n++;
  end

  // =====================================================
  // shared helpers
  task automatic end_sim();
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string msg);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input logic [15:0] d, input logic [2:0] f);
    video_partner_i.tick(d, f);
  endtask

  task automatic start(input parallel_video_data_port_pkg::port_cfg_t c);
    @(negedge clk);
    cfg[0].enable = 1'b0;
    repeat (4) @(negedge clk);
    rxq.delete();
    expq.delete();
    done_n = 0;
    rdy_n = 0;
    sol_n = 0;
    fld_n = 0;
    cfg[0] = c;
    cfg[0].enable = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_done(input int n);
    int k;
    for (k = 0; k < n && done_n == 0; k++) tick(16'h0077, 3'h0);
    if (done_n == 0) begin
      n_fail++;
      $display("BAD %0t no done", $time);
      end_sim();
    end
  endtask

  // =====================================================
  // general input: trigger, delay, exact count, width mask
  task automatic gp_in(input logic [3:0] sel, input int dly);
    parallel_video_data_port_pkg::port_cfg_t c;
    logic [15:0] mask;
    int k;
    c = '0;
    c.mode = parallel_video_data_port_pkg::MODE_GP_IN;
    c.width_sel = sel;
    c.sync_to_data_delay = 16'(dly);
    c.transfer_count = 16'h0003;
    mask = (sel == 4'h0) ? 16'h00FF : 16'((17'h1 << (9 + sel)) - 1);
    start(c);
    repeat (2) tick(16'h0BAD, 3'h0);
    tick(16'h0BAD, 3'h1);
    for (k = 0; k < dly; k++) tick(16'h0D0D, 3'h0);
    for (k = 0; k < 3; k++) tick(16'hF5A0 + 16'(k), 3'h0);
    repeat (2) tick(16'h0BAD, 3'h0);
    chk(16'(rxq.size()), 16'h0003, "count");
    for (k = 0; k < 3 && k < rxq.size(); k++)
      chk(rxq[k], (16'hF5A0 + 16'(k)) & mask, "word");
    chk(16'(done_n), 16'h0001, "done");
    chk(16'(d_oe[0]), 16'h0000, "in oe");
  endtask

  // =====================================================
  // capture and output: generated syncs, directions, counts
  task automatic sync_gen(input parallel_video_data_port_pkg::port_mode_t m,
                          input logic [2:0] dir, input logic [1:0] cnt);
    parallel_video_data_port_pkg::port_cfg_t c;
    int k, h, v, b;
    logic is_out;
    c = '0;
    c.mode = m;
    c.fs_dir = dir;
    c.fs_count = cnt;
    c.line_period = 16'h0004;
    c.hsync_width = 16'h0001;
    c.frame_lines = 16'h0002;
    c.vsync_lines = 16'h0001;
    c.transfer_count = 16'h0028;
    is_out = (m == parallel_video_data_port_pkg::MODE_GP_OUT);
    tx_data[0] = 16'hA5C3;
    tx_valid[0] = 1'b1;
    start(c);
    repeat (4) tick(16'h00AA, 3'h0);
    h = 0;
    v = 0;
    b = 0;
    // eight rises span two lines and one whole frame
    for (k = 0; k < 8; k++) begin
      tick(16'h00AA, 3'h0);
      #40;
      if (fs_out[0][0] === 1'b1) h++;
      if (fs_out[0][1] === 1'b1) v++;
      if (fs_out[0][2] === 1'b1) b++;
    end
    chk(16'(h), 16'h0002, "hsync");
    chk(16'(v), 16'h0004, "vsync");
    if (is_out) chk(16'(b), 16'h0001, "third sync");
    chk(16'(fs_oe[0]), 16'(dir), "sync oe");
    chk(16'(d_oe[0]), 16'(is_out), "data oe");
    wait_done(100);
    if (is_out) begin
      chk(16'(rdy_n), 16'h0028, "taken");
      chk(d_out[0], 16'h00C3, "out word");
    end else
      chk(16'(rxq.size()), 16'h0028, "captured");
    tx_valid[0] = 1'b0;
  endtask

  // =====================================================
  // video stream: cls bit0 active, bit1 blanking, bit2 entire
  int vmode;
  logic [3:0] vsel;
  task automatic w(input logic [7:0] d, input logic [2:0] cls);
    logic [15:0] x;
    // 10-bit samples carry the byte in their top eight bits
    x = (vsel == 4'h1) ? {6'h00, d, 2'h0} : {8'h00, d};
    if (cls[vmode]) expq.push_back(x);
    tick(x, 3'h0);
  endtask

  task automatic pre(input logic f, input logic v, input logic h,
                     input logic [2:0] cls);
    w(8'hFF, cls);
    w(8'h00, cls);
    w(8'h00, cls);
    w({1'b1, f, v, h, 4'h0}, cls);
  endtask

  task automatic video(input parallel_video_data_port_pkg::port_mode_t m,
                       input int sel);
    parallel_video_data_port_pkg::port_cfg_t c;
    int k;
    c = '0;
    c.mode = m;
    c.transfer_count = 16'h0002;
    c.width_sel = vsel;
    vmode = sel;
    start(c);
    pre(1'b1, 1'b1, 1'b1, 3'h0);
    pre(1'b0, 1'b1, 1'b1, 3'h0);
    w(8'h21, 3'h6);
    w(8'h22, 3'h6);
    pre(1'b0, 1'b1, 1'b0, 3'h4);
    w(8'h23, 3'h6);
    w(8'h24, 3'h6);
    chk(16'(status[0].synced), 16'h0001, "synced");
    chk(16'(status[0].vblank), 16'h0001, "vblank");
    pre(1'b0, 1'b0, 1'b1, 3'h4);
    w(8'h31, 3'h4);
    w(8'h32, 3'h4);
    pre(1'b0, 1'b0, 1'b0, 3'h4);
    for (k = 0; k < 3; k++) w(8'h41 + 8'(k), 3'h5);
    pre(1'b0, 1'b0, 1'b1, 3'h4);
    w(8'h33, 3'h4);
    pre(1'b0, 1'b0, 1'b0, 3'h4);
    for (k = 0; k < 3; k++) w(8'h44 + 8'(k), 3'h5);
    pre(1'b0, 1'b0, 1'b1, 3'h4);
    repeat (8) w(8'h50, 3'h0);
    if (sel == 2) begin
      // where the sync word itself lands is left open
      for (k = 0; k < 8 && rxq.size() > 0 && rxq[0] !== 16'h0021; k++)
        void'(rxq.pop_front());
    end else
      chk(16'(rxq.size()), 16'(expq.size()), "video count");
    for (k = 0; k < expq.size(); k++)
      chk(k < rxq.size() ? rxq[k] : 16'hXXXX, expq[k], "video");
    if (sel == 0) chk(16'(done_n), 16'h0001, "lines");
    chk(16'(sol_n), 16'h0003, "start codes");
    chk(16'(fld_n), 16'h0002, "field flips");
    chk(16'(status[0].busy), 16'(sel != 0), "busy");
  endtask

  // =====================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    cfg[0] = '0;
    cfg[1] = '0;
    tx_data = '0;
    tx_valid = '0;
    b_n = 0;
    vsel = 4'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    gp_in(4'h0, 2);
    gp_in(4'h1, 0);
    gp_in(4'h7, 3);
    sync_gen(parallel_video_data_port_pkg::MODE_GP_OUT, 3'h7, 2'h3);
    sync_gen(parallel_video_data_port_pkg::MODE_GP_FRAME, 3'h3, 2'h2);
    video(parallel_video_data_port_pkg::MODE_ITU_ACTIVE, 0);
    video(parallel_video_data_port_pkg::MODE_ITU_VBI, 1);
    video(parallel_video_data_port_pkg::MODE_ITU_FIELD, 2);
    vsel = 4'h1;
    video(parallel_video_data_port_pkg::MODE_ITU_ACTIVE, 0);
    chk(16'(b_n), 16'h0000, "idle port b");
    chk(16'(d_oe[1]), 16'h0000, "port b oe");
    end_sim();
  end
endmodule // parallel_video_data_port_tb
`default_nettype wire
